// ### design/stn_pkg.sv
// shared constants, types and functions of the serial trim access block
package stn_pkg;
    localparam int CLK_MHZ = 250;
    localparam int UNLOCK_DEADLINE_MS = 8;
    localparam int UNLOCK_DEADLINE_CYC = UNLOCK_DEADLINE_MS * 1000 * CLK_MHZ;
    localparam int READ_DELAY_US = 50;
    localparam int READ_DELAY_CYC = READ_DELAY_US * CLK_MHZ;
    localparam int MIN_RATE_KBPS = 32;
    localparam int HALF_BIT_MAX_CYC = CLK_MHZ * 1000 / (2 * MIN_RATE_KBPS);
    localparam int CNT_W = 16;
    localparam int READ_FRAME_BITS = 12;
    localparam int WRITE_FRAME_BITS = 42;
    localparam int ACK_FRAME_BITS = 35;
    localparam logic [5:0] ADDR_TRIM = 6'h00;
    localparam logic [5:0] ADDR_DEBUG = 6'h10;
    localparam logic [5:0] ADDR_SHADOW = 6'h20;
    localparam logic [5:0] ADDR_KEY = 6'h24;
    localparam int ADDR_SPACE_BIT = 5;
    localparam logic [29:0] UNLOCK_KEY = 30'h2781_1f77;
    localparam int LOCK_BIT = 23;
    localparam int DBG_OUT_OFF_BIT = 0;
    localparam int DBG_SHADOW_BIT = 1;
    localparam logic [1:0] DEBUG_RESET = 2'h0;
    localparam logic [22:0] SHADOW_RESET = 23'h0;
    localparam logic [2:0] CRC_POLY = 3'h3;
    localparam logic [2:0] CRC_INIT = 3'h0;
    typedef enum logic [1:0] {
        ECC_OK = 2'b00, ECC_FIXED = 2'b01, ECC_FAIL = 2'b10
    } stn_ecc_t;
    typedef struct packed {
        logic limiter_off;
        logic output_invert;
        logic signed [8:0] zero_field_level_trim;
        logic [1:0] coarse_gain_range;
        logic signed [8:0] fine_gain_trim;
    } stn_trim_t;
    typedef struct packed {
        logic frame_done;
        logic [5:0] nbits;
        logic [41:0] bits;
        logic [CNT_W-1:0] half;
    } stn_rx_t;
    // msb first over the low n bits of d
    function automatic logic [2:0] crc3(input logic [38:0] d, input int n);
        logic [2:0] c;
        c = CRC_INIT;
        for (int i = 38; i >= 0; i--) begin
            if (i < n) begin
                c = {c[1:0], 1'b0} ^ ((c[2] ^ d[i]) ? CRC_POLY : 3'h0);
            end
        end
        return c;
    endfunction
    // check bits: hamming over positions 1..29 plus overall parity
    function automatic logic [5:0] ham_check(input logic [23:0] d);
        logic [5:0] c;
        int j;
        c = 6'h00;
        j = 0;
        for (int p = 1; p < 30; p++) begin
            if ((p & (p - 1)) != 0) begin
                for (int k = 0; k < 5; k++) begin
                    if (p[k]) begin
                        c[k] = c[k] ^ d[j];
                    end
                end
                j++;
            end
        end
        c[5] = ^{c[4:0], d};
        return c;
    endfunction
endpackage

// ### design/stn_ecc_decode.sv
// corrects one stored word and grades its integrity
`timescale 1ns/1ps
module stn_ecc_decode (
    input wire logic [29:0] word,
    output logic [23:0] data,
    output stn_pkg::stn_ecc_t status
);
    import stn_pkg::*;
    logic [5:0] chk;
    logic [4:0] syn;
    logic par;
    int j;
    always_comb begin
        j = 0;
        chk = ham_check(word[23:0]);
        syn = chk[4:0] ^ word[28:24];
        par = ^word;
        data = word[23:0];
        for (int p = 1; p < 30; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (par && syn == p[4:0]) begin
                    data[j] = ~data[j];
                end
                j++;
            end
        end
        // odd parity means one flip; even parity with syndrome means two
        if (!par && syn == 5'h00) begin
            status = ECC_OK;
        end else if (par) begin
            status = ECC_FIXED;
        end else begin
            status = ECC_FAIL;
        end
    end
endmodule

// ### design/stn_man_rx.sv
// manchester frame receiver with per-frame bit rate tracking
`timescale 1ns/1ps
module stn_man_rx (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic line,
    output stn_pkg::stn_rx_t rx
);
    import stn_pkg::*;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_FIRST = 2'b01, RX_RUN = 2'b10
    } stn_rx_state_t;
    stn_rx_state_t state;
    logic prev;
    logic done;
    logic [5:0] nbits;
    logic [41:0] bits;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] half;
    logic rise;
    logic fall;
    assign rise = line & ~prev;
    assign fall = ~line & prev;
    assign rx = '{frame_done: done, nbits: nbits, bits: bits, half: half};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b1;
            state <= RX_IDLE;
            done <= 1'b0;
            nbits <= 6'h00;
            bits <= 42'h0;
            cnt <= '0;
            half <= '0;
        end else begin
            prev <= line;
            done <= 1'b0;
            if (cnt != '1) begin
                cnt <= cnt + 1'b1;
            end
            case (state)
                RX_IDLE: begin
                    // line idles high, so a frame opens with a fall
                    if (fall) begin
                        cnt <= '0;
                        state <= RX_FIRST;
                    end
                end
                RX_FIRST: begin
                    if (rise) begin
                        half <= cnt + 1'b1;
                        bits <= 42'h0;
                        nbits <= 6'h01;
                        cnt <= '0;
                        state <= RX_RUN;
                    end else if (int'(cnt) > 2 * HALF_BIT_MAX_CYC) begin
                        state <= RX_IDLE;
                    end
                end
                RX_RUN: begin
                    // edges before 1.5 half bits are cell boundaries
                    if ((rise | fall) && cnt >= half + (half >> 1)) begin
                        bits <= {bits[40:0], fall};
                        if (nbits != 6'h3f) begin
                            nbits <= nbits + 1'b1;
                        end
                        cnt <= '0;
                    end else if (int'(cnt) > 3 * int'(half)) begin
                        done <= 1'b1;
                        state <= RX_IDLE;
                    end
                end
                default: state <= RX_IDLE;
            endcase
        end
    end
endmodule

// ### design/stn_nvm_access.sv
// serial access, unlock, ecc store and trim outputs of the sensor
// Behaviour
// - address top bit picks store or registers; debug at 0x10 is a register
// - read answer: sync, thirty data, crc
// - answer holds data low, status above
// - check bits computed here, sent ones ignored
// - key write at 0x24 unlocks access
// - key first and in time, else refused
// - word zero holds gain, range, level trims
// - word zero holds invert, limiter, lock flags
// - nine bit trims are two's complement
// - word one is a free scratch field
// - debug bit zero turns analog output off
// - debug bit one enables shadow override
// - stored word: 24 data, 6 check bits
// - hamming correction active from power up
// - status: ok, corrected, uncorrectable
// - uncorrectable error: output off, no response
// - every answer carries thirty data bits
// - manchester: one falls, zero rises
// - answer starts after the read delay
`timescale 1ns/1ps
module stn_nvm_access #(
    parameter int NVM_WORDS = 2,
    parameter int UNLOCK_DEADLINE = stn_pkg::UNLOCK_DEADLINE_CYC,
    parameter int READ_DELAY = stn_pkg::READ_DELAY_CYC,
    parameter logic [29:0] NVM_INIT = 30'h0
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic vcc_manchester_in,
    output logic sensor_output_pin_out,
    output logic sensor_output_pin_oe,
    output logic analog_output_enable,
    output logic field_response_enable,
    output stn_pkg::stn_trim_t trim,
    output logic access_open,
    output logic ecc_fault
);
    import stn_pkg::*;
    localparam int IDX_W = $clog2(NVM_WORDS);
    localparam int DL_W = $clog2(UNLOCK_DEADLINE + 1);
    localparam int WT_W = $clog2(READ_DELAY + 2);

    typedef enum logic [1:0] {
        ACC_WAIT = 2'b00, ACC_OPEN = 2'b01, ACC_REFUSED = 2'b10
    } stn_access_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b10
    } stn_tx_t;

    logic [2:0] vin_sync;
    logic vin_level;
    stn_rx_t rx;
    stn_access_t access;
    stn_tx_t tx_state;
    logic [DL_W-1:0] dl_cnt;
    logic [29:0] nvm [NVM_WORDS];
    logic [1:0] debug;
    logic [22:0] shadow;
    logic fault;
    logic rd_ok;
    logic wr_ok;
    logic [5:0] r_addr;
    logic [5:0] w_addr;
    logic [29:0] w_data;
    logic is_key;
    logic can_access;
    logic lock_set;
    logic nvm_wr;
    logic [23:0] w0_data;
    stn_ecc_t w0_status;
    logic [23:0] rd_data;
    stn_ecc_t rd_status;
    logic [29:0] rd_word;
    logic [29:0] payload;
    logic [IDX_W-1:0] r_idx;
    logic r_in_nvm;
    logic [22:0] trim_src;
    logic [ACK_FRAME_BITS-1:0] ack_frame;
    logic [5:0] bit_idx;
    logic phase;
    logic [CNT_W-1:0] half_r;
    logic [CNT_W-1:0] tcnt;
    logic [WT_W-1:0] wait_cnt;
    logic [WT_W-1:0] wait_tgt;
    logic [WT_W-1:0] next_wait_tgt;
    int tgt_i;

    // three stage sampling; a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vin_sync <= 3'h7;
        end else begin
            vin_sync <= {vin_sync[1:0], vcc_manchester_in};
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            vin_level <= 1'b1;
        end else if (vin_sync[1] == vin_sync[2]) begin
            vin_level <= vin_sync[2];
        end
    end

    stn_man_rx u_rx (
        .mclk(mclk),
        .rst_b(rst_b),
        .line(vin_level),
        .rx(rx)
    );

    assign r_addr = rx.bits[8:3];
    assign w_addr = rx.bits[38:33];
    assign w_data = rx.bits[32:3];

    // crc must match or frame dropped
    always_comb begin
        rd_ok = rx.frame_done && int'(rx.nbits) == READ_FRAME_BITS
            && rx.bits[11:10] == 2'b00 && rx.bits[9]
            && crc3({30'h0, rx.bits[11:3]}, 9) == rx.bits[2:0];
        wr_ok = rx.frame_done && int'(rx.nbits) == WRITE_FRAME_BITS
            && rx.bits[41:40] == 2'b00 && !rx.bits[39]
            && crc3(rx.bits[41:3], 39) == rx.bits[2:0];
    end

    assign is_key = wr_ok && w_addr == ADDR_KEY && w_data == UNLOCK_KEY;
    assign can_access = access == ACC_OPEN;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dl_cnt <= '0;
        end else if (int'(dl_cnt) < UNLOCK_DEADLINE) begin
            dl_cnt <= dl_cnt + 1'b1;
        end
    end

    // first frame must be key, in time
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            access <= ACC_WAIT;
        end else begin
            case (access)
                ACC_WAIT: begin
                    if (int'(dl_cnt) >= UNLOCK_DEADLINE) begin
                        access <= ACC_REFUSED;
                    end else if (rd_ok || wr_ok) begin
                        access <= is_key ? ACC_OPEN : ACC_REFUSED;
                    end
                end
                ACC_OPEN: access <= ACC_OPEN;
                // refusal lasts until the next power cycle
                default: access <= ACC_REFUSED;
            endcase
        end
    end

    stn_ecc_decode u_ecc_w0 (
        .word(nvm[0]),
        .data(w0_data),
        .status(w0_status)
    );

    assign lock_set = w0_data[LOCK_BIT];

    // space selected by top address bit, except debug at 0x10
    assign r_in_nvm = !r_addr[ADDR_SPACE_BIT] && r_addr != ADDR_DEBUG
        && int'(r_addr) < NVM_WORDS;
    assign r_idx = r_addr[IDX_W-1:0];
    assign nvm_wr = can_access && wr_ok && !w_addr[ADDR_SPACE_BIT]
        && w_addr != ADDR_DEBUG && int'(w_addr) < NVM_WORDS && !lock_set;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NVM_WORDS; i++) begin
                nvm[i] <= NVM_INIT;
            end
        end else if (nvm_wr) begin
            nvm[w_addr[IDX_W-1:0]] <= {ham_check(w_data[23:0]), w_data[23:0]};
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            debug <= DEBUG_RESET;
        end else if (can_access && wr_ok && w_addr == ADDR_DEBUG) begin
            debug <= w_data[1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            shadow <= SHADOW_RESET;
        end else if (can_access && wr_ok && w_addr == ADDR_SHADOW) begin
            shadow <= w_data[22:0];
        end
    end

    assign rd_word = nvm[r_idx];

    stn_ecc_decode u_ecc_rd (
        .word(rd_word),
        .data(rd_data),
        .status(rd_status)
    );

    always_comb begin
        payload = 30'h0;
        if (r_addr == ADDR_SHADOW) begin
            payload = {7'h0, shadow};
        end else if (r_in_nvm) begin
            payload = {4'h0, rd_status, rd_data};
            if (r_idx == '0) begin
                payload[LOCK_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fault <= 1'b0;
        end else if (w0_status == ECC_FAIL) begin
            fault <= 1'b1;
        end else if (rd_ok && r_in_nvm && rd_status == ECC_FAIL) begin
            fault <= 1'b1;
        end
    end

    // delay less the receiver's end timeout and an eighth bit
    always_comb begin
        tgt_i = READ_DELAY - (5 * int'(rx.half)) / 2 - int'(rx.half) / 4;
        if (tgt_i < 1) begin
            tgt_i = 1;
        end
        next_wait_tgt = WT_W'(tgt_i);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state <= TX_IDLE;
            ack_frame <= '0;
            half_r <= '0;
            wait_cnt <= '0;
            wait_tgt <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (rd_ok && can_access) begin
                        ack_frame <= {2'b00, payload,
                            crc3({7'h0, 2'b00, payload}, 32)};
                        half_r <= rx.half;
                        wait_cnt <= '0;
                        wait_tgt <= next_wait_tgt;
                        tx_state <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (wait_cnt >= wait_tgt) begin
                        tx_state <= TX_SEND;
                    end else begin
                        wait_cnt <= wait_cnt + 1'b1;
                    end
                end
                TX_SEND: begin
                    if (phase && tcnt == half_r - 1'b1 && bit_idx == 6'h00) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // msb first, two half cells per bit
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_idx <= 6'h00;
            phase <= 1'b0;
            tcnt <= '0;
        end else if (tx_state != TX_SEND) begin
            bit_idx <= 6'(ACK_FRAME_BITS - 1);
            phase <= 1'b0;
            tcnt <= '0;
        end else if (tcnt == half_r - 1'b1) begin
            tcnt <= '0;
            phase <= ~phase;
            if (phase && bit_idx != 6'h00) begin
                bit_idx <= bit_idx - 1'b1;
            end
        end else begin
            tcnt <= tcnt + 1'b1;
        end
    end

    // one: high then low; zero: low then high
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sensor_output_pin_out <= 1'b1;
            sensor_output_pin_oe <= 1'b0;
        end else if (tx_state == TX_SEND) begin
            sensor_output_pin_out <= ack_frame[bit_idx] ^ phase;
            sensor_output_pin_oe <= 1'b1;
        end else begin
            sensor_output_pin_out <= 1'b1;
            sensor_output_pin_oe <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            analog_output_enable <= 1'b0;
            field_response_enable <= 1'b0;
        end else begin
            analog_output_enable <= !debug[DBG_OUT_OFF_BIT] && !fault;
            field_response_enable <= !fault;
        end
    end

    // shadow overrides bits 22 to 0
    assign trim_src = debug[DBG_SHADOW_BIT] ? shadow : w0_data[22:0];

    // trim fields; the gain and level trims are signed nine bit codes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trim <= '0;
        end else begin
            trim.fine_gain_trim <= signed'(trim_src[8:0]);
            trim.coarse_gain_range <= trim_src[10:9];
            trim.zero_field_level_trim <= signed'(trim_src[19:11]);
            trim.output_invert <= trim_src[21];
            trim.limiter_off <= trim_src[22];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            access_open <= 1'b0;
            ecc_fault <= 1'b0;
        end else begin
            access_open <= access == ACC_OPEN;
            ecc_fault <= fault;
        end
    end
endmodule

// ### testbench/stn_nvm_access_sva.sv
// port checker of the serial trim access block
`timescale 1ns/1ps
module stn_nvm_access_sva #(
    parameter int READ_DELAY = 200
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic vcc_manchester_in,
    input wire logic sensor_output_pin_out,
    input wire logic sensor_output_pin_oe,
    input wire logic analog_output_enable,
    input wire logic field_response_enable,
    input wire stn_pkg::stn_trim_t trim,
    input wire logic access_open,
    input wire logic ecc_fault
);
    import stn_pkg::*;
    logic [15:0] oe_cnt;
    logic [15:0] lo_len;
    logic lo_done;
    logic [15:0] quiet;
    logic line_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oe_cnt <= '0;
        end else begin
            oe_cnt <= sensor_output_pin_oe ? oe_cnt + 16'h1 : '0;
        end
    end
    // first low half cell is the sync half, so it measures the rate
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lo_len <= '0;
            lo_done <= 1'b0;
        end else if (!sensor_output_pin_oe) begin
            lo_len <= '0;
            lo_done <= 1'b0;
        end else if (sensor_output_pin_out) begin
            lo_done <= 1'b1;
        end else if (!lo_done) begin
            lo_len <= lo_len + 16'h1;
        end
    end
    // saturating, so a long idle never wraps into a false pass
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            quiet <= '0;
            line_q <= 1'b1;
        end else begin
            line_q <= vcc_manchester_in;
            quiet <= (vcc_manchester_in != line_q) ? '0 :
                     quiet + {15'h0, ~&quiet};
        end
    end
    idle_high_a: assert property (
        !sensor_output_pin_oe |-> sensor_output_pin_out)
        else $error("pin not high while released");
    ack_sync_a: assert property (
        $rose(sensor_output_pin_oe) |-> !sensor_output_pin_out)
        else $error("answer does not open with a zero");
    ack_length_a: assert property (
        $fell(sensor_output_pin_oe) |-> oe_cnt == 70 * lo_len)
        else $error("answer is not seventy half cells");
    read_delay_a: assert property (
        $rose(sensor_output_pin_oe) |->
        quiet >= READ_DELAY / 2 && quiet <= 2 * READ_DELAY)
        else $error("answer start out of window");
    ack_locked_a: assert property (
        sensor_output_pin_oe |-> access_open)
        else $error("answer while access closed");
    open_hold_a: assert property (
        access_open |=> access_open)
        else $error("access dropped");
    fault_hold_a: assert property (
        ecc_fault |=> ecc_fault)
        else $error("fault flag cleared");
    fault_off_a: assert property (
        ecc_fault |-> ##2 (!analog_output_enable && !field_response_enable))
        else $error("output still active after fault");
endmodule
bind stn_nvm_access stn_nvm_access_sva #(.READ_DELAY(READ_DELAY))
    stn_nvm_access_sva_inst (
    .mclk, .rst_b, .vcc_manchester_in, .sensor_output_pin_out,
    .sensor_output_pin_oe, .analog_output_enable, .field_response_enable,
    .trim, .access_open, .ecc_fault);

// ### testbench/stn_ctl_model.sv
// programming controller model: frames out, answer captured
`timescale 1ns/1ps
module stn_ctl_model #(
    parameter int HALF = 10,
    parameter int WAIT = 800
) (
    input wire logic mclk,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic line
);
    initial line = 1'b1;
    // msb first, one falls mid cell, rate fixed per frame
    // rate scaled up to keep the run short; the receiver tracks each frame's rate
    task automatic send(input logic [41:0] f, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            line <= f[i];
            repeat (HALF) @(posedge mclk);
            line <= ~f[i];
            repeat (HALF) @(posedge mclk);
        end
        line <= 1'b1;
    endtask
    // each bit read in the middle of its first half cell
    task automatic recv(output logic [34:0] a, output logic seen);
        seen = 1'b0;
        a = '0;
        for (int t = 0; t < WAIT && !seen; t++) begin
            @(posedge mclk);
            seen = pin_oe;
        end
        if (seen) begin
            repeat (HALF / 2) @(posedge mclk);
            for (int i = 34; i >= 0; i--) begin
                a[i] = pin_out;
                repeat (2 * HALF) @(posedge mclk);
            end
        end
    endtask
endmodule

// ### testbench/test_sensor_trim_serial_nvm_access.sv
// self-checking bench of the serial trim access block
`timescale 1ns/1ps
module test_sensor_trim_serial_nvm_access;
    import stn_pkg::*;
    localparam int HALF = 10;
    localparam int DEADLINE = 20000;
    localparam int RDLY = 200;
    // read flag, location, write data, expected answer data
    localparam logic [66:0] ROWS [8] = '{
        {1'b0, 6'h01, 30'h3f12_3456, 30'h0},
        {1'b1, 6'h01, 30'h0, 30'h0012_3456},
        {1'b0, 6'h00, 30'h0028_04ff, 30'h0},
        {1'b1, 6'h00, 30'h0, 30'h0028_04ff},
        {1'b1, 6'h05, 30'h0, 30'h0},
        {1'b0, 6'h20, 30'h0000_abcd, 30'h0},
        {1'b1, 6'h20, 30'h0, 30'h0000_abcd},
        {1'b1, 6'h10, 30'h0, 30'h0}
    };
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic line;
    logic line_b;
    logic pin_out;
    logic pin_oe;
    logic aen;
    logic fen;
    stn_trim_t trim;
    logic acc;
    logic b_out;
    logic b_oe;
    logic b_acc;
    logic c_aen;
    logic c_fen;
    logic c_fault;
    int miscompares = 0;
    int n_compared = 0;
    always #2 mclk = ~mclk;
    stn_nvm_access #(.UNLOCK_DEADLINE(DEADLINE), .READ_DELAY(RDLY))
    stn_nvm_access_inst (.mclk, .rst_b, .vcc_manchester_in(line),
        .sensor_output_pin_out(pin_out), .sensor_output_pin_oe(pin_oe),
        .analog_output_enable(aen), .field_response_enable(fen),
        .trim, .access_open(acc), .ecc_fault());
    // one flipped data bit in every stored word
    stn_nvm_access #(.UNLOCK_DEADLINE(DEADLINE), .READ_DELAY(RDLY),
        .NVM_INIT(30'h1)) stn_nvm_access_b_inst (.mclk, .rst_b,
        .vcc_manchester_in(line_b), .sensor_output_pin_out(b_out),
        .sensor_output_pin_oe(b_oe), .analog_output_enable(),
        .field_response_enable(), .trim(), .access_open(b_acc),
        .ecc_fault());
    // two flipped data bits: beyond correction
    stn_nvm_access #(.NVM_INIT(30'h3)) stn_nvm_access_c_inst (.mclk,
        .rst_b, .vcc_manchester_in(1'b1), .sensor_output_pin_out(),
        .sensor_output_pin_oe(), .analog_output_enable(c_aen),
        .field_response_enable(c_fen), .trim(), .access_open(),
        .ecc_fault(c_fault));
    stn_ctl_model #(.HALF(HALF), .WAIT(4 * RDLY)) stn_ctl_model_inst (
        .mclk, .pin_out, .pin_oe, .line);
    stn_ctl_model #(.HALF(HALF), .WAIT(4 * RDLY)) stn_ctl_model_b_inst (
        .mclk, .pin_out(b_out), .pin_oe(b_oe), .line(line_b));
    task automatic cb(input string n, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cw(input string n, input logic [31:0] e,
                      input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [2:0] crc(input logic [38:0] d, input int n);
        logic [2:0] c;
        c = 3'h0;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[1:0], 1'b0} ^ ({3{c[2] ^ d[i]}} & 3'h3);
        end
        return c;
    endfunction
    task automatic results;
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (8) @(posedge mclk);
        cb("pin idle", 1'b1, pin_out);
        cb("pin drive", 1'b0, pin_oe);
        cb("access", 1'b0, acc);
        cb("analog", 1'b0, aen);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    task automatic wr(input logic b, input logic [5:0] a,
                      input logic [29:0] d, input logic [2:0] x);
        logic [38:0] f;
        // sync, write direction, location, data, crc
        f = {2'b00, 1'b0, a, d};
        if (b) begin
            stn_ctl_model_b_inst.send({f, crc(f, 39) ^ x}, 42);
        end else begin
            stn_ctl_model_inst.send({f, crc(f, 39) ^ x}, 42);
        end
        repeat (8 * HALF) @(posedge mclk);
    endtask
    task automatic rd(input logic b, input logic [5:0] a,
                      input logic [29:0] e, input logic want);
        logic [41:0] f;
        logic [34:0] k;
        logic seen;
        f = {30'h0, 2'b00, 1'b1, a, crc({30'h0, 2'b00, 1'b1, a}, 9)};
        if (b) begin
            stn_ctl_model_b_inst.send(f, 12);
            stn_ctl_model_b_inst.recv(k, seen);
        end else begin
            stn_ctl_model_inst.send(f, 12);
            stn_ctl_model_inst.recv(k, seen);
        end
        cb("answer", want, seen);
        if (want) begin
            cw("ack", {2'b00, e}, k[34:3]);
            cw("crc", crc({7'h0, k[34:3]}, 32), k[2:0]);
        end
        repeat (8 * HALF) @(posedge mclk);
    endtask
    initial begin
        do_reset();
        cb("analog", 1'b1, aen);
        cb("field", 1'b1, fen);
        cb("fault", 1'b1, c_fault);
        cb("c analog", 1'b0, c_aen);
        cb("c field", 1'b0, c_fen);
        wr(1'b0, ADDR_KEY, UNLOCK_KEY, 3'h0);
        wr(1'b1, ADDR_KEY, UNLOCK_KEY, 3'h0);
        cb("access", 1'b1, acc);
        cb("b access", 1'b1, b_acc);
        rd(1'b1, 6'h01, 30'h0100_0000, 1'b1);
        foreach (ROWS[i]) begin
            if (ROWS[i][66]) begin
                rd(1'b0, ROWS[i][65:60], ROWS[i][29:0], 1'b1);
            end else begin
                wr(1'b0, ROWS[i][65:60], ROWS[i][59:30], 3'h0);
            end
        end
        cw("trim", 32'h0018_04ff, {10'h0, trim});
        wr(1'b0, ADDR_DEBUG, 30'h2, 3'h0);
        cw("shadow", 32'h0000_abcd, {10'h0, trim});
        wr(1'b0, ADDR_DEBUG, 30'h1, 3'h0);
        cb("analog", 1'b0, aen);
        cw("trim", 32'h0018_04ff, {10'h0, trim});
        wr(1'b0, 6'h01, 30'h0000_0777, 3'h1);
        rd(1'b0, 6'h01, 30'h0012_3456, 1'b1);
        wr(1'b0, ADDR_TRIM, 30'h0080_00aa, 3'h0);
        rd(1'b0, ADDR_TRIM, 30'h0000_00aa, 1'b1);
        wr(1'b0, ADDR_TRIM, 30'h0000_0055, 3'h0);
        rd(1'b0, ADDR_TRIM, 30'h0000_00aa, 1'b1);
        do_reset();
        wr(1'b0, ADDR_KEY, UNLOCK_KEY ^ 30'h1, 3'h0);
        wr(1'b0, ADDR_KEY, UNLOCK_KEY, 3'h0);
        cb("access", 1'b0, acc);
        rd(1'b0, 6'h01, 30'h0, 1'b0);
        do_reset();
        repeat (DEADLINE) @(posedge mclk);
        wr(1'b0, ADDR_KEY, UNLOCK_KEY, 3'h0);
        cb("access", 1'b0, acc);
        results();
    end
    initial begin
        repeat (80000) @(posedge mclk);
        miscompares++;
        results();
    end
endmodule
